/* design/sdt_pkg.sv */
// Package for the SDRAM init and timing controller block.
// Assumes a single 250 MHz clock domain and the plain register port.
package sdt_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h08;
  localparam logic [7:0] ADDR_LOWPWR = 8'h10;
  localparam logic [7:0] ADDR_MEMTYPE = 8'h14;
  localparam logic [7:0] ADDR_EXTRA = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  // Reset values
  localparam logic [31:0] TIMING_RST = 32'h852372c0;
  // Timing field positions
  localparam int XSR_LSB = 28;
  localparam int RAS_LSB = 24;
  localparam int RCD_LSB = 20;
  localparam int RP_LSB = 16;
  localparam int RC_LSB = 12;
  localparam int WR_LSB = 8;
  localparam int BW_BIT = 7;
  localparam int NB_BIT = 4;
  localparam int NR_LSB = 2;
  localparam int NC_LSB = 0;
  // Mode field encodings
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_NOP = 3'h1;
  localparam logic [2:0] MODE_PALL = 3'h2;
  localparam logic [2:0] MODE_REFRESH = 3'h4;
  // Command pins {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESEL = 4'hf;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam int A10_BIT = 10;
  // Power-up pause before any pin toggles
  localparam int PAUSE_US = 200;
  localparam int CLK_MHZ = 250;
  localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
  typedef enum logic [2:0] {
    SDT_IDLE = 3'b000,
    SDT_ACT = 3'b001,
    SDT_RCD = 3'b011,
    SDT_RW = 3'b010,
    SDT_RAS = 3'b110,
    SDT_PRE = 3'b111,
    SDT_RP = 3'b101
  } sdt_state_e;
  // SDRAM pin bundle
  typedef struct packed {
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [12:0] addr;
    logic cke;
  } sdt_pins_s;
  // Split memory address
  typedef struct packed {
    logic [1:0] bank;
    logic [12:0] row;
    logic [10:0] col;
  } sdt_addr_s;
endpackage

/* design/sdt_addr_map.sv */
// Address splitter: CPU byte address to bank, row, column.
// Assumes the geometry selects come from the timing register.
`timescale 1ns/10ps
`default_nettype none
module sdt_addr_map (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [27:0] cpu_addr_in,
  input wire logic [1:0] col_sel_in,
  input wire logic row_sel_in,
  output sdt_pkg::sdt_addr_s map_out
);
  logic [3:0] col_bits;
  logic [4:0] row_lsb;
  logic [4:0] bank_lsb;
  logic [27:0] row_raw;
  logic [27:0] bank_raw;
  logic [10:0] col_mask;
  // Column width is 8 to 11, row 12 or 13; bit 0 is the byte lane
  always_comb begin
    col_bits = 4'h8 + {2'h0, col_sel_in};
    row_lsb = 5'h01 + {1'h0, col_bits};
    bank_lsb = row_lsb + (row_sel_in ? 5'h0d : 5'h0c);
    row_raw = cpu_addr_in >> row_lsb;
    bank_raw = cpu_addr_in >> bank_lsb;
    col_mask = ~(11'h7ff << col_bits);
  end
  // Registered so the split never lies on the command path
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      map_out <= '0;
    end else begin
      map_out.col <= cpu_addr_in[11:1] & col_mask;
      map_out.row <= row_sel_in ? row_raw[12:0] : {1'b0, row_raw[11:0]};
      map_out.bank <= bank_raw[1:0];
    end
  end
endmodule
`default_nettype wire

/* design/sdt_ctrl.sv */
// SDRAM init and timing controller: registers, command sequencer.
// Assumes memory accesses arrive as one-cycle strobes with a ready reply.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Byte lane bit zero, then columns, rows of 12 or 13, then two bank bits.
// - Upper bank bit drives high bank pin, lower bit drives low bank pin.
// - Mode 1 turns each write into a no-operation command.
// - Mode 2 turns each write into a precharge of all banks.
// - Mode 4 turns each write into one auto-refresh; software does eight.
// - Self-refresh exit delay in bits 31:28, reset eight.
// - Active to precharge minimum in bits 27:24, reset five.
// - Row to column delay in bits 23:20, reset two.
// - Row precharge delay in bits 19:16, reset three.
module sdt_ctrl #(
  parameter int PAUSE_CYCLES = sdt_pkg::PAUSE_CYC
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [27:0] mem_addr_in,
  output logic mem_done_out,
  output logic [3:0] sd_cmd_out,
  output logic bank_select_high_out,
  output logic bank_select_low_out,
  output logic [12:0] sd_addr_out,
  output logic sdram_clock_enable_pin_out
);
  logic [31:0] timing_reg;
  logic [2:0] mode_reg;
  logic [31:0] lowpwr_reg;
  logic [2:0] memtype_reg;
  logic unaligned_access_support_reg;
  logic [17:0] pause_reg;
  logic pause_done_reg;
  logic [3:0] refresh_cnt_reg;
  logic [3:0] wait_reg;
  logic [3:0] ras_reg;
  logic [3:0] xsr_reg;
  logic pend_reg;
  logic pend_we_reg;
  logic [27:0] pend_addr_reg;
  logic cfg_done_reg;
  sdt_pkg::sdt_state_e state_reg;
  sdt_pkg::sdt_pins_s pins_reg;
  sdt_pkg::sdt_addr_s map;
  logic [3:0] self_refresh_exit_delay;
  logic [3:0] active_to_precharge_delay;
  logic [3:0] row_to_column_delay;
  logic [3:0] row_precharge_delay;

  assign self_refresh_exit_delay = timing_reg[sdt_pkg::XSR_LSB +: 4];
  assign active_to_precharge_delay = timing_reg[sdt_pkg::RAS_LSB +: 4];
  assign row_to_column_delay = timing_reg[sdt_pkg::RCD_LSB +: 4];
  assign row_precharge_delay = timing_reg[sdt_pkg::RP_LSB +: 4];

  sdt_addr_map u_map (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .cpu_addr_in(pend_addr_reg),
    .col_sel_in(timing_reg[sdt_pkg::NC_LSB +: 2]),
    .row_sel_in(timing_reg[sdt_pkg::NR_LSB]),
    .map_out(map)
  );

  // Register writes
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      timing_reg <= sdt_pkg::TIMING_RST;
      mode_reg <= sdt_pkg::MODE_NORMAL;
      lowpwr_reg <= '0;
      memtype_reg <= '0;
      unaligned_access_support_reg <= 1'b0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        sdt_pkg::ADDR_TIMING: timing_reg <= reg_wdata_in;
        sdt_pkg::ADDR_MODE: mode_reg <= reg_wdata_in[2:0];
        sdt_pkg::ADDR_LOWPWR: lowpwr_reg <= reg_wdata_in;
        sdt_pkg::ADDR_MEMTYPE: memtype_reg <= reg_wdata_in[2:0];
        sdt_pkg::ADDR_EXTRA: unaligned_access_support_reg <= reg_wdata_in[8];
        default: ;
      endcase
    end
  end

  // Register reads, one cycle later; unmapped reads give zero
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        sdt_pkg::ADDR_TIMING: reg_rdata_out <= timing_reg;
        sdt_pkg::ADDR_MODE: reg_rdata_out <= {29'h0, mode_reg};
        sdt_pkg::ADDR_LOWPWR: reg_rdata_out <= lowpwr_reg;
        sdt_pkg::ADDR_MEMTYPE: reg_rdata_out <= {29'h0, memtype_reg};
        sdt_pkg::ADDR_EXTRA: reg_rdata_out <= {23'h0, unaligned_access_support_reg, 8'h0};
        sdt_pkg::ADDR_STATUS: reg_rdata_out <= {24'h0, refresh_cnt_reg, 1'b0,
                                                state_reg == sdt_pkg::SDT_IDLE,
                                                cfg_done_reg, pause_done_reg};
        default: reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

  // Power-up pause starts once the memory type is chosen
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      cfg_done_reg <= 1'b0;
      pause_reg <= '0;
      pause_done_reg <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == sdt_pkg::ADDR_MEMTYPE) begin
        cfg_done_reg <= 1'b1;
      end
      if (cfg_done_reg && !pause_done_reg) begin
        if (pause_reg == 18'(PAUSE_CYCLES - 1)) begin
          pause_done_reg <= 1'b1;
        end
        pause_reg <= pause_reg + 18'h00001;
      end
    end
  end

  // Accept one access at a time; held until the sequencer finishes
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      pend_reg <= 1'b0;
      pend_we_reg <= 1'b0;
      pend_addr_reg <= '0;
    end else if (mem_req_in && !pend_reg) begin
      pend_reg <= 1'b1;
      pend_we_reg <= mem_we_in;
      pend_addr_reg <= mem_addr_in;
    end else if (mem_done_out) begin
      pend_reg <= 1'b0;
    end
  end

  // Exit delay counts from the clock enable rising; reloaded while it is low
  // so a timing value written before the clock enable rises is picked up before the first command
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      xsr_reg <= '0;
    end else if (!pins_reg.cke) begin
      xsr_reg <= self_refresh_exit_delay;
    end else if (xsr_reg != 4'h0) begin
      xsr_reg <= xsr_reg - 4'h1;
    end
  end

  // Command sequencer; pins stay quiet until the pause has elapsed
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state_reg <= sdt_pkg::SDT_IDLE;
      pins_reg <= '{cmd: sdt_pkg::CMD_DESEL, bank: 2'h0, addr: 13'h0, cke: 1'b0};
      wait_reg <= '0;
      ras_reg <= '0;
      mem_done_out <= 1'b0;
      refresh_cnt_reg <= '0;
    end else begin
      mem_done_out <= 1'b0;
      pins_reg.cmd <= pause_done_reg ? sdt_pkg::CMD_NOP : sdt_pkg::CMD_DESEL;
      pins_reg.cke <= pause_done_reg;
      if (ras_reg != 4'h0) begin
        ras_reg <= ras_reg - 4'h1;
      end
      if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end
      case (state_reg)
        sdt_pkg::SDT_IDLE: begin
          // One cycle after capture so the address split is valid
          if (pend_reg && pause_done_reg && !mem_done_out && xsr_reg == 4'h0) begin
            state_reg <= sdt_pkg::SDT_ACT;
          end
        end
        sdt_pkg::SDT_ACT: begin
          state_reg <= sdt_pkg::SDT_IDLE;
          mem_done_out <= 1'b1;
          if (mode_reg == sdt_pkg::MODE_NOP && pend_we_reg) begin
            pins_reg.cmd <= sdt_pkg::CMD_NOP;
          end else if (mode_reg == sdt_pkg::MODE_PALL && pend_we_reg) begin
            pins_reg.cmd <= sdt_pkg::CMD_PRE;
            pins_reg.addr <= 13'h1 << sdt_pkg::A10_BIT;
          end else if (mode_reg == sdt_pkg::MODE_REFRESH && pend_we_reg) begin
            pins_reg.cmd <= sdt_pkg::CMD_REF;
            refresh_cnt_reg <= refresh_cnt_reg + 4'h1;
          end else if (mode_reg == sdt_pkg::MODE_NORMAL) begin
            mem_done_out <= 1'b0;
            pins_reg.cmd <= sdt_pkg::CMD_ACT;
            pins_reg.bank <= map.bank;
            pins_reg.addr <= map.row;
            ras_reg <= active_to_precharge_delay;
            wait_reg <= row_to_column_delay;
            state_reg <= sdt_pkg::SDT_RCD;
          end
        end
        sdt_pkg::SDT_RCD: begin
          if (wait_reg <= 4'h1) begin
            state_reg <= sdt_pkg::SDT_RW;
          end
        end
        sdt_pkg::SDT_RW: begin
          pins_reg.cmd <= pend_we_reg ? sdt_pkg::CMD_WRITE : sdt_pkg::CMD_READ;
          pins_reg.addr <= {2'h0, map.col};
          state_reg <= sdt_pkg::SDT_RAS;
        end
        sdt_pkg::SDT_RAS: begin
          if (ras_reg <= 4'h1) begin
            state_reg <= sdt_pkg::SDT_PRE;
          end
        end
        sdt_pkg::SDT_PRE: begin
          pins_reg.cmd <= sdt_pkg::CMD_PRE;
          pins_reg.addr <= 13'h1 << sdt_pkg::A10_BIT;
          wait_reg <= row_precharge_delay;
          state_reg <= sdt_pkg::SDT_RP;
        end
        sdt_pkg::SDT_RP: begin
          if (wait_reg <= 4'h1) begin
            state_reg <= sdt_pkg::SDT_IDLE;
            mem_done_out <= 1'b1;
          end
        end
        default: state_reg <= sdt_pkg::SDT_IDLE;
      endcase
    end
  end

  // Pin outputs straight from the pin register, so every pin is a flop
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sd_cmd_out <= sdt_pkg::CMD_DESEL;
      bank_select_high_out <= 1'b0;
      bank_select_low_out <= 1'b0;
      sd_addr_out <= '0;
      sdram_clock_enable_pin_out <= 1'b0;
    end else begin
      sd_cmd_out <= pins_reg.cmd;
      bank_select_high_out <= pins_reg.bank[1];
      bank_select_low_out <= pins_reg.bank[0];
      sd_addr_out <= pins_reg.addr;
      sdram_clock_enable_pin_out <= pins_reg.cke;
    end
  end
endmodule
`default_nettype wire

/* verif/sdt_ctrl_props.sv */
// Checker on controller ports: pin quiet time, init commands, gaps.
// Assumes it is bound into the controller with the same pause length.
`timescale 1ns/10ps
`default_nettype none
module sdt_ctrl_props #(
  parameter int PAUSE_CYCLES = sdt_pkg::PAUSE_CYC
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic mem_done_out,
  input wire logic [3:0] sd_cmd_out,
  input wire logic [12:0] sd_addr_out,
  input wire logic sdram_clock_enable_pin_out
);
  logic [31:0] tq;
  logic [2:0] mq;
  logic wq;
  int unsigned pc, ac, rc, kc;
  wire is_act = sd_cmd_out == sdt_pkg::CMD_ACT;
  wire is_pre = sd_cmd_out == sdt_pkg::CMD_PRE;
  wire is_rw = sd_cmd_out inside {sdt_pkg::CMD_READ, sdt_pkg::CMD_WRITE};
  wire fin = mem_done_out && wq;
  // Shadow timing, mode and access kind as software set them
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      tq <= 32'h852372c0;
      mq <= 3'h0;
      wq <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == sdt_pkg::ADDR_TIMING) tq <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == sdt_pkg::ADDR_MODE) mq <= reg_wdata_in[2:0];
      if (mem_req_in) wq <= mem_we_in;
    end
  end
  // Cycle counts; ac, rc and kc saturate so long idle spans never wrap into a false gap
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      pc <= 0;
      ac <= 255;
      rc <= 255;
      kc <= 0;
    end else begin
      kc <= !sdram_clock_enable_pin_out ? 0 : (kc < 255 ? kc + 1 : kc);
      pc <= (reg_wr_in && reg_addr_in == sdt_pkg::ADDR_MEMTYPE) ? 0 : pc + 1;
      ac <= is_act ? 1 : (ac < 255 ? ac + 1 : ac);
      rc <= is_pre ? 1 : (rc < 255 ? rc + 1 : rc);
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  a_pins_quiet: assert property (
    !sdram_clock_enable_pin_out |-> sd_cmd_out == sdt_pkg::CMD_DESEL) else $error("Early cmd");
  a_pause_len: assert property (
    $rose(sdram_clock_enable_pin_out) |-> pc >= PAUSE_CYCLES - 1) else $error("Short pause");
  a_nop_cmd: assert property (
    fin && mq == 3'h1 |-> sd_cmd_out == sdt_pkg::CMD_NOP ##1 sd_cmd_out == sdt_pkg::CMD_NOP)
    else $error("No NOP");
  a_pall_cmd: assert property (
    fin && mq == 3'h2 |-> ##[0:1] is_pre && sd_addr_out[10]) else $error("No precharge all");
  a_ref_cmd: assert property (
    fin && mq == 3'h4 |-> ##[0:1] sd_cmd_out == sdt_pkg::CMD_REF) else $error("No refresh");
  a_rcd_gap: assert property (is_rw |-> ac >= tq[23:20]) else $error("Row to col short");
  a_ras_gap: assert property (is_pre |-> ac >= tq[27:24]) else $error("Act to pre short");
  a_rp_gap: assert property (is_act |-> rc >= tq[19:16]) else $error("Precharge short");
  a_xsr_gap: assert property (is_act |-> kc >= tq[31:28]) else $error("Exit delay short");
  cover property (is_act);
  cover property (fin && mq == 3'h4);
  cover property ($rose(sdram_clock_enable_pin_out));
endmodule
bind sdt_ctrl sdt_ctrl_props #(.PAUSE_CYCLES(PAUSE_CYCLES)) i_sdt_ctrl_props (.mclk_in,
  .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .mem_req_in, .mem_we_in, .mem_done_out,
  .sd_cmd_out, .sd_addr_out, .sdram_clock_enable_pin_out);
`default_nettype wire

/* verif/sdt_sdram_model.sv */
// SDRAM device model: decodes commands, counts activates, precharges and refreshes, latches addresses.
// Assumes pins are sampled on the controller clock.
`timescale 1ns/10ps
`default_nettype none
module sdt_sdram_model (
  input wire logic clk_in,
  input wire logic [3:0] cmd_in,
  input wire logic [1:0] bank_in,
  input wire logic [12:0] addr_in,
  output logic [7:0] n_act_out = 8'h00,
  output logic [7:0] n_pre_out = 8'h00,
  output logic [7:0] n_ref_out = 8'h00,
  output logic [1:0] bank_out = 2'h0,
  output logic [12:0] row_out = 13'h0,
  output logic [7:0] col_out = 8'h00
);
  // Only all-bank precharge counts, a single-bank one would not finish init
  always @(posedge clk_in) begin
    case (cmd_in)
      sdt_pkg::CMD_ACT: begin
        n_act_out <= n_act_out + 8'h01;
        bank_out <= bank_in;
        row_out <= addr_in;
      end
      sdt_pkg::CMD_PRE: n_pre_out <= n_pre_out + {7'h00, addr_in[10]};
      sdt_pkg::CMD_REF: n_ref_out <= n_ref_out + 8'h01;
      sdt_pkg::CMD_READ, sdt_pkg::CMD_WRITE: col_out <= addr_in[7:0];
      default: ;
    endcase
  end
endmodule
`default_nettype wire

/* verif/test_sdram_init_and_timing.sv */
// Testbench: register setup, init command sequence, normal accesses.
// Assumes a shortened pause and reset geometry of 8 columns, 12 rows.
`timescale 1ns/10ps
`default_nettype none
module test_sdram_init_and_timing;
  localparam int PAUSE = 20;
  logic mclk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, mem_req_in = 1'b0, mem_we_in = 1'b0;
  logic [27:0] mem_addr_in = 28'h0;
  logic [31:0] reg_rdata_out;
  logic mem_done_out, bank_select_high_out, bank_select_low_out, sdram_clock_enable_pin_out;
  logic [3:0] sd_cmd_out;
  logic [12:0] sd_addr_out, row;
  logic [7:0] n_act, n_pre, n_ref, col;
  logic [1:0] bank;
  int bad_count = 0;
  int check_count = 0;
  sdt_ctrl #(.PAUSE_CYCLES(PAUSE)) i_sdt_ctrl (.mclk_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mem_req_in, .mem_we_in, .mem_addr_in, .mem_done_out,
    .sd_cmd_out, .bank_select_high_out, .bank_select_low_out, .sd_addr_out,
    .sdram_clock_enable_pin_out);
  sdt_sdram_model i_sdt_sdram_model (.clk_in(mclk_in), .cmd_in(sd_cmd_out),
    .bank_in({bank_select_high_out, bank_select_low_out}), .addr_in(sd_addr_out),
    .n_act_out(n_act), .n_pre_out(n_pre), .n_ref_out(n_ref), .bank_out(bank), .row_out(row),
    .col_out(col));
  always #2 mclk_in = ~mclk_in;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask
  // One access; done is a single-cycle pulse, so look after every edge
  task automatic mem(input logic we, input logic [27:0] a);
    int n;
    @(posedge mclk_in);
    mem_req_in <= 1'b1;
    mem_we_in <= we;
    mem_addr_in <= a;
    @(posedge mclk_in);
    mem_req_in <= 1'b0;
    n = 0;
    while (mem_done_out !== 1'b1 && n < 200) begin
      @(posedge mclk_in);
      #1 n++;
    end
    chk(32'(n < 200), 32'h1);
    repeat (2) @(posedge mclk_in);
    #1;
  endtask
  task automatic t_regs();
    rd(sdt_pkg::ADDR_TIMING, 32'h852372c0);
    wr(sdt_pkg::ADDR_TIMING, 32'h363472c0);
    rd(sdt_pkg::ADDR_TIMING, 32'h363472c0);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 32'h0);
    wr(sdt_pkg::ADDR_EXTRA, 32'h100);
    rd(sdt_pkg::ADDR_EXTRA, 32'h100);
    $display("t_regs done");
  endtask
  task automatic t_init();
    wr(sdt_pkg::ADDR_LOWPWR, 32'h27);
    wr(sdt_pkg::ADDR_MEMTYPE, 32'h0);
    // Clock enable must still be low just short of the pause, high after it
    repeat (PAUSE - 1) @(posedge mclk_in);
    #1 chk({31'h0, sdram_clock_enable_pin_out}, 32'h0);
    repeat (5) @(posedge mclk_in);
    #1 chk({31'h0, sdram_clock_enable_pin_out}, 32'h1);
    rd(sdt_pkg::ADDR_LOWPWR, 32'h27);
    wr(sdt_pkg::ADDR_MODE, 32'h1);
    rd(sdt_pkg::ADDR_MODE, 32'h1);
    mem(1'b1, 28'h0);
    chk({8'h0, n_act, n_pre, n_ref}, 32'h0);
    wr(sdt_pkg::ADDR_MODE, 32'h2);
    rd(sdt_pkg::ADDR_MODE, 32'h2);
    mem(1'b1, 28'h0);
    chk({8'h0, n_act, n_pre, n_ref}, 32'h100);
    wr(sdt_pkg::ADDR_MODE, 32'h4);
    rd(sdt_pkg::ADDR_MODE, 32'h4);
    repeat (8) mem(1'b1, 28'h0);
    chk({8'h0, n_act, n_pre, n_ref}, 32'h108);
    rd(sdt_pkg::ADDR_STATUS, 32'h87);
    $display("t_init done");
  endtask
  // Upper address bits set on the read: unused in this geometry
  task automatic t_norm();
    wr(sdt_pkg::ADDR_MODE, 32'h0);
    mem(1'b1, {5'h0, 2'h2, 12'h5a5, 8'h3c, 1'h0});
    chk({9'h0, bank, row, col}, {9'h0, 2'h2, 13'h5a5, 8'h3c});
    mem(1'b0, {5'h1f, 2'h1, 12'ha5a, 8'hc3, 1'h1});
    chk({9'h0, bank, row, col}, {9'h0, 2'h1, 13'ha5a, 8'hc3});
    chk({8'h0, n_act, n_pre, n_ref}, 32'h20308);
    $display("t_norm done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_init();
    t_norm();
    close_out();
  end
  // Whole run is well under 1000 cycles
  initial begin
    repeat (5000) @(posedge mclk_in);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
